// ===== rtl/utc_pkg.sv
// constants and register layout for the upper timer control block
// Functional notes
// - With the idle-stop bit set the timer halts during chip idle, otherwise it keeps running.
// - Gated accumulation is ignored on the external clock and, on the internal clock, gates counting with the pin.
// - The prescale field in bits 5 to 4 divides the input clock: 01 by 8, 10 by 64, 11 by 256.
// - Clock-source bit 1 set counts rising edges of the external timer pin, clear counts the peripheral clock.
// - While the partner is in 32-bit mode its control register governs this timer and ours is ignored.
// - Unimplemented bits 14, 12 to 7, 3 to 2 and 0 read as zero.
package utc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // ----------------------------------------------------------------
  // byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_TIMER_ON    = 15;
  localparam int unsigned BIT_IDLE_STOP   = 13;
  localparam int unsigned BIT_GATE_EN     = 6;
  localparam int unsigned BIT_PRESCALE_HI = 5;
  localparam int unsigned BIT_PRESCALE_LO = 4;
  localparam int unsigned BIT_CLK_SOURCE  = 1;
  localparam int unsigned BIT_WIDE_MODE   = 3;

  // implemented bits; everything else reads zero
  localparam logic [REG_W-1:0] CTRL_MASK  = 16'ha072;
  localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [REG_W-1:0] COUNT_RESET = 16'h0000;

  // status word bits
  localparam int unsigned STS_RUNNING  = 0;
  localparam int unsigned STS_WIDE     = 1;
  localparam int unsigned STS_IDLE_HLT = 2;

  // ----------------------------------------------------------------
  // prescale codes and ratios
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_DIV1   = 2'h0,
    PS_DIV8   = 2'h1,
    PS_DIV64  = 2'h2,
    PS_DIV256 = 2'h3
  } utc_prescale_e;

  localparam int unsigned PS_CNT_W  = 8;
  localparam logic [PS_CNT_W-1:0] PS_TOP_DIV1   = 8'h00;
  localparam logic [PS_CNT_W-1:0] PS_TOP_DIV8   = 8'h07;
  localparam logic [PS_CNT_W-1:0] PS_TOP_DIV64  = 8'h3f;
  localparam logic [PS_CNT_W-1:0] PS_TOP_DIV256 = 8'hff;

  // bus answer: one wait cycle after the request is seen
  localparam int unsigned BUS_WAIT_CYCLES = 1;

endpackage : utc_pkg

// ===== rtl/utc_prescaler.sv
// input clock prescaler for the upper timer
module utc_prescaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  import utc_pkg::*;

  logic [PS_CNT_W-1:0] cnt_q;
  logic [PS_CNT_W-1:0] cnt_d;
  logic [PS_CNT_W-1:0] top;

  // ----------------------------------------------------------------
  // ratio select
  // ----------------------------------------------------------------
  always_comb begin
    unique case (utc_prescale_e'(sel_i))
      PS_DIV1:   top = PS_TOP_DIV1;
      PS_DIV8:   top = PS_TOP_DIV8;
      PS_DIV64:  top = PS_TOP_DIV64;
      PS_DIV256: top = PS_TOP_DIV256;
    endcase
  end

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    tick_o = 1'b0;
    if (clear_i) begin
      cnt_d = '0;
    end else if (tick_i) begin
      // >= so a ratio lowered mid-count still wraps promptly
      if (cnt_q >= top) begin
        cnt_d  = '0;
        tick_o = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : utc_prescaler

// ===== rtl/utc_top.sv
// upper timer: control register, prescaler, 16-bit counter and Avalon-MM slave
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
module utc_top (
  input  wire logic                       CLK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic [utc_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                       AVS_READ_I,
  input  wire logic                       AVS_WRITE_I,
  input  wire logic [utc_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]                 AVS_BYTEENABLE_I,
  output logic      [utc_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic                            AVS_WAITREQUEST_O,
  input  wire logic                       IDLE_MODE_I,
  input  wire logic [utc_pkg::REG_W-1:0]  LOWER_PARTNER_CONTROL_I,
  input  wire logic                       EXTERNAL_TIMER_CLOCK_PIN_I,
  output logic      [utc_pkg::REG_W-1:0]  COUNT_O,
  output logic                            RUNNING_O
);
  import utc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [REG_W-1:0]  ctrl_q;
  logic [REG_W-1:0]  ctrl_d;
  logic [REG_W-1:0]  count_q;
  logic [REG_W-1:0]  count_d;
  logic              pin_q;
  logic              pin_d;
  logic              running_q;
  logic              running_d;
  logic              wait_q;
  logic              wait_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // ----------------------------------------------------------------
  // effective controls
  // ----------------------------------------------------------------
  logic             wide_mode;
  logic [REG_W-1:0] eff_ctrl;
  logic             timer_on_bit;
  logic             idle_stop_bit;
  logic             gated_accumulate_enable;
  logic [1:0]       input_prescale_select;
  logic             clock_source_select;
  logic             idle_halt;
  logic             run;
  logic             pin_rise;
  logic             src_tick;
  logic             ps_tick;
  logic             ps_clear;
  logic             bus_req;
  logic             bus_take;
  logic             wr_ctrl;
  logic             wr_count;

  always_comb begin
    wide_mode = LOWER_PARTNER_CONTROL_I[BIT_WIDE_MODE];
    // partner register takes over every function in 32-bit mode
    eff_ctrl  = wide_mode ? LOWER_PARTNER_CONTROL_I : ctrl_q;
    timer_on_bit            = eff_ctrl[BIT_TIMER_ON];
    idle_stop_bit           = eff_ctrl[BIT_IDLE_STOP];
    gated_accumulate_enable = eff_ctrl[BIT_GATE_EN];
    input_prescale_select   = eff_ctrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
    clock_source_select     = eff_ctrl[BIT_CLK_SOURCE];
    // combined timer keeps running in idle only with idle-stop clear
    idle_halt = IDLE_MODE_I & idle_stop_bit;
    run       = timer_on_bit & ~idle_halt;
  end

  // ----------------------------------------------------------------
  // input clock source
  // ----------------------------------------------------------------
  always_comb begin
    pin_d    = EXTERNAL_TIMER_CLOCK_PIN_I;
    pin_rise = EXTERNAL_TIMER_CLOCK_PIN_I & ~pin_q;
    if (clock_source_select) begin
      // gate bit has no say on the external clock
      src_tick = pin_rise;
    end else if (gated_accumulate_enable) begin
      // peripheral clock counted only while the pin is high
      src_tick = EXTERNAL_TIMER_CLOCK_PIN_I;
    end else begin
      src_tick = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // restart the divide on a control write so a new ratio starts clean;
  // in wide mode our register is ignored, so its writes must not disturb the divide
  assign ps_clear = (wr_ctrl & ~wide_mode) | ~timer_on_bit;

  utc_prescaler u_prescaler (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .clear_i (ps_clear),
    .tick_i  (src_tick & run),
    .sel_i   (input_prescale_select),
    .tick_o  (ps_tick)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  always_comb begin
    bus_req  = AVS_READ_I | AVS_WRITE_I;
    // request completes at the edge where waitrequest is seen low
    bus_take = bus_req & ~wait_q;
    wr_ctrl  = bus_take & AVS_WRITE_I & (AVS_ADDRESS_I == OFS_CTRL);
    wr_count = bus_take & AVS_WRITE_I & (AVS_ADDRESS_I == OFS_COUNT);
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      if (AVS_BYTEENABLE_I[0]) begin
        ctrl_d[7:0] = AVS_WRITEDATA_I[7:0] & CTRL_MASK[7:0];
      end
      if (AVS_BYTEENABLE_I[1]) begin
        ctrl_d[15:8] = AVS_WRITEDATA_I[15:8] & CTRL_MASK[15:8];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    count_d   = count_q;
    running_d = run;
    if (wr_count) begin
      // software write wins over a tick in the same cycle
      if (AVS_BYTEENABLE_I[0]) begin
        count_d[7:0] = AVS_WRITEDATA_I[7:0];
      end
      if (AVS_BYTEENABLE_I[1]) begin
        count_d[15:8] = AVS_WRITEDATA_I[15:8];
      end
    end else if (ps_tick) begin
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      count_q   <= COUNT_RESET;
      running_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      running_q <= running_d;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if (bus_req & wait_q) begin
      wait_d  = 1'b0;
      rdata_d = '0;
      if (AVS_READ_I) begin
        unique case (AVS_ADDRESS_I)
          OFS_CTRL: begin
            rdata_d[REG_W-1:0] = ctrl_q & CTRL_MASK;
          end
          OFS_COUNT: begin
            rdata_d[REG_W-1:0] = count_q;
          end
          OFS_STATUS: begin
            rdata_d[STS_RUNNING]  = run;
            rdata_d[STS_WIDE]     = wide_mode;
            rdata_d[STS_IDLE_HLT] = idle_halt;
          end
          default: begin
            rdata_d = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA_O    = rdata_q;
  assign AVS_WAITREQUEST_O = wait_q;
  assign COUNT_O           = count_q;
  assign RUNNING_O         = running_q;

endmodule : utc_top

// ===== test/upper_timer_control_tb.sv
// self-checking bench for the upper timer control block
module upper_timer_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import utc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, idle = 1'b0, go = 1'b0;
  logic        wreq, run, busy, pin;
  logic        hlt_exp, on_exp;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'ha3da;
  logic [15:0] lpc = 16'h0, cnt, wide_set[4] = '{16'h8008, 16'ha008, 16'h8048, 16'h8018};
  logic [9:0]  edges = 10'h0;
  logic [1:0]  half = 2'h0;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0, num_checks = 0, cyc = 0, ratio[4] = '{1, 8, 64, 256};
  always #10 clk = !clk;
  utc_top u_utc_top (.CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .IDLE_MODE_I(idle), .LOWER_PARTNER_CONTROL_I(lpc),
    .EXTERNAL_TIMER_CLOCK_PIN_I(pin), .COUNT_O(cnt), .RUNNING_O(run));
  utc_pin_src u_utc_pin_src (.clk_i(clk), .go_i(go), .edges_i(edges), .half_i(half),
    .busy_o(busy), .pin_o(pin));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // request held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rdx
  task automatic scen(input logic [15:0] l, input logic i, input logic [15:0] c, input int e,
                      input int k);
    lpc  <= l;
    idle <= i;
    bus(1'b1, OFS_CTRL, {16'h0, c});
    bus(1'b1, OFS_COUNT, 32'h0);
    seed = xs(seed);
    half  <= seed[1:0];
    edges <= e[9:0];
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    // settle margin for the counter pipeline
    repeat (6) @(posedge clk);
    rdx(OFS_COUNT, k);
    chk({16'h0, cnt}, 32'(k));
  endtask : scen
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) chk(rdat, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdx(OFS_CTRL, 32'h0);
    rdx(OFS_COUNT, 32'h0);
    for (int j = 0; j < 4; j++) begin
      seed = xs(seed);
      bus(1'b1, OFS_CTRL, seed);
      rdx(OFS_CTRL, {16'h0, seed[15:0] & CTRL_MASK});
      rdx(4'hc, 32'h0);
    end
    for (int c = 0; c < 4; c++) scen(16'h0, 1'b0, 16'h8002 | 16'(c << 4), 3 * ratio[c], 3);
    scen(16'h0, 1'b0, 16'h8042, 5, 5);
    scen(16'h0, 1'b0, 16'h8040, 0, 0);
    scen(16'h0, 1'b0, 16'h0002, 5, 0);
    scen(16'h0, 1'b1, 16'ha002, 5, 0);
    scen(16'h0, 1'b1, 16'h8002, 5, 5);
    scen(16'h0008, 1'b0, 16'h8002, 5, 0);
    scen(16'ha00a, 1'b1, 16'h0, 5, 0);
    scen(16'h800a, 1'b1, 16'h0, 5, 5);
    // gate on the internal clock: four pulses, each high for two cycles
    lpc  <= 16'h0;
    idle <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h8040);
    bus(1'b1, OFS_COUNT, 32'h0);
    half  <= 2'h1;
    edges <= 10'h4;
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (6) @(posedge clk);
    rdx(OFS_COUNT, 32'h8);
    chk({16'h0, cnt}, 32'h8);
    idle <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      lpc <= wide_set[j];
      repeat (12) @(posedge clk);
      hlt_exp = idle & wide_set[j][BIT_IDLE_STOP];
      on_exp  = wide_set[j][BIT_TIMER_ON] & !hlt_exp;
      chk({31'h0, run}, {31'h0, on_exp});
      rdx(OFS_STATUS, {29'h0, hlt_exp, 1'b1, on_exp});
    end
    test_done();
  end
endmodule : upper_timer_control_tb

// ===== test/utc_checker.sv
// concurrent checks on the upper timer ports
module utc_checker
  import utc_pkg::*;
(
  input logic        CLK_I,
  input logic        SYS_RST_I,
  input logic [3:0]  AVS_ADDRESS_I,
  input logic        AVS_READ_I,
  input logic        AVS_WRITE_I,
  input logic [31:0] AVS_READDATA_O,
  input logic        AVS_WAITREQUEST_O,
  input logic        IDLE_MODE_I,
  input logic [15:0] LOWER_PARTNER_CONTROL_I,
  input logic        EXTERNAL_TIMER_CLOCK_PIN_I,
  input logic [15:0] COUNT_O,
  input logic        RUNNING_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [15:0] lp;
  logic        wd;
  logic        run;
  logic        pin;
  assign lp  = LOWER_PARTNER_CONTROL_I;
  assign wd  = lp[BIT_WIDE_MODE] && !AVS_WRITE_I;
  assign run = lp[BIT_TIMER_ON] && !(IDLE_MODE_I && lp[BIT_IDLE_STOP]);
  assign pin = EXTERNAL_TIMER_CLOCK_PIN_I;
  // internal clock, no gate, partner control steady
  sequence fast_s;
    wd && run && lp[5:4] == 2'h0 && !lp[BIT_CLK_SOURCE] && !lp[BIT_GATE_EN] && $stable(lp);
  endsequence
  sequence slow_s;
    wd && run && lp[5:4] != 2'h0 && !lp[1] && !lp[BIT_GATE_EN] && $stable(lp);
  endsequence
  count_step_a: assert property (
    fast_s [*3] |=> COUNT_O == $past(COUNT_O) + 16'h1) else $error("count did not step");
  div_gap_a: assert property (
    slow_s [*3] ##0 COUNT_O != $past(COUNT_O) |=> $stable(COUNT_O)) else $error("divider skipped");
  hold_off_a: assert property (
    (wd && !lp[BIT_TIMER_ON]) [*3] |=> $stable(COUNT_O)) else $error("counted while off");
  idle_halt_a: assert property (
    (wd && IDLE_MODE_I && lp[BIT_IDLE_STOP]) [*3] |=> $stable(COUNT_O)) else $error("idle count");
  gate_low_a: assert property (
    (wd && run && !lp[1] && lp[BIT_GATE_EN] && !pin) [*4] |=> $stable(COUNT_O))
    else $error("counted with gate low");
  ext_hold_a: assert property (
    (wd && run && lp[1] && $stable(pin)) [*4] |=> $stable(COUNT_O)) else $error("no pin edge");
  run_flag_a: assert property (
    (lp[BIT_WIDE_MODE] && $stable(lp) && $stable(IDLE_MODE_I)) [*2] |=> RUNNING_O == $past(run))
    else $error("running flag wrong");
  ctrl_read_a: assert property (
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == OFS_CTRL
    |-> (AVS_READDATA_O & ~{16'h0, CTRL_MASK}) == 32'h0) else $error("reserved bit read set");
endmodule : utc_checker

bind utc_top utc_checker u_utc_checker (.CLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .IDLE_MODE_I, .LOWER_PARTNER_CONTROL_I,
  .EXTERNAL_TIMER_CLOCK_PIN_I, .COUNT_O, .RUNNING_O);

// ===== test/utc_pin_src.sv
// external clock source driving the timer pin
module utc_pin_src (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [9:0] edges_i,
  input  wire logic [1:0] half_i,
  output logic            busy_o,
  output logic            pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left_q = 10'h0;
  logic [1:0] ph_q   = 2'h0;
  logic       p_q    = 1'b0;
  logic       b_q    = 1'b0;
  assign pin_o  = p_q;
  assign busy_o = b_q;
  // pin rests low between bursts so a burst of n gives n rising edges
  always @(posedge clk_i) begin
    if (go_i) begin
      left_q <= edges_i;
      b_q    <= edges_i != 10'h0;
      ph_q   <= half_i;
    end else if (b_q) begin
      if (ph_q != 2'h0) begin
        ph_q <= ph_q - 2'h1;
      end else begin
        ph_q <= half_i;
        p_q  <= !p_q;
        if (p_q) begin
          left_q <= left_q - 10'h1;
          b_q    <= left_q != 10'h1;
        end
      end
    end
  end
endmodule : utc_pin_src
